// ---- core/sar_ctrl_map.svh ----
// Register offsets, field positions, reset values and timing constants of the converter control
`ifndef SAR_CTRL_MAP_SVH
`define SAR_CTRL_MAP_SVH

// APB register offsets (byte addresses)
`define SAR_OFF_CTRL      8'h00
`define SAR_OFF_STATUS    8'h04
`define SAR_OFF_RESULT    8'h08
`define SAR_OFF_LAST      8'h0c

// Control register fields
`define SAR_CTRL_NAP      0
`define SAR_CTRL_SLEEP    1
`define SAR_CTRL_RST      2'h0

// Status register fields
`define SAR_ST_BUSY       0
`define SAR_ST_PD         1
`define SAR_ST_RANGE      2
`define SAR_ST_FORMAT     3
`define SAR_ST_VALID      4
`define SAR_ST_LVL_LO     8
`define SAR_ST_LVL_HI     11

// Result register field: fifo valid flag above the 16-bit code
`define SAR_RES_VALID     16

// Search constants
`define SAR_BITS          16
`define SAR_MSB_IDX       4'hf
`define SAR_MSB_TRIAL     16'h8000
`define SAR_CODE_RST      16'h0000
`define SAR_STEP_RST      8'h00

// Coding selections {range, format}
`define SAR_SEL_FD_2C     2'b00
`define SAR_SEL_FD_OB     2'b01
`define SAR_SEL_PB_2C     2'b10
`define SAR_SEL_PU_SB     2'b11

// Timing: clock period and fastest sample period in ns
`define SAR_CLK_PERIOD_NS 100
`define SAR_SAMPLE_NS     400
`define SAR_SAMPLE_CYC    ((`SAR_SAMPLE_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)

`endif

// ---- core/sar_ctrl_pkg.sv ----
// Types shared by the converter control files
package sar_ctrl_pkg;

    // Conversion sequencer states, Gray coded along acquire, convert, hand over
    typedef enum logic [1:0] {
        ST_ACQ  = 2'b00,
        ST_CONV = 2'b01,
        ST_HOLD = 2'b11
    } conv_state_t;

    // Analog span driven to the front end
    typedef enum logic [1:0] {
        SPAN_FULL_DIFF = 2'b00,
        SPAN_BIPOLAR   = 2'b01,
        SPAN_UNIPOLAR  = 2'b10
    } span_t;

endpackage

// ---- core/result_fifo.sv ----
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [AW:0]      level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;

    // Pointer arithmetic wraps naturally only for powers of two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("result_fifo: DEPTH must be a power of two, at least 2");
    end

    // Extra pointer bit tells full from empty
    assign level     = wr_ptr_r - rd_ptr_r;
    assign in_ready  = (level != DEPTH[AW:0]);
    assign out_valid = (level != '0);
    assign out_data  = mem[rd_ptr_r[AW-1:0]];

    // Write side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= '0;
        end else if (in_valid && in_ready) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge pclk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    // Read side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_r <= '0;
        end else if (out_valid && out_ready) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

endmodule // result_fifo

// ---- core/sar_conversion_control.sv ----
// Successive-approximation conversion sequencer with APB registers and result FIFO
//
// Functional notes
// - Alternate acquisition and conversion phases
// - Start input falling edge begins conversion
// - Binary search, one bit per step, MSB first
// - Assemble result for selected output port
// - Internal step timer times the conversion
// - Target of 2.5 million conversions per second; at the 100 ns clock, 16 steps plus two clocks per conversion give about 555 thousand
// - Parallel result is that conversion's own code
// - Nap and sleep reduced-power states
// - Three selectable input spans, 65536 codes
// - Coding chosen by range and format pins
// - Offset binary is two's complement, MSB inverted
// - Pin pair maps to span and coding
// - Busy high through conversion, falls when ready
// - Reset aborts conversion, data bus released
// - Power-down request ignores conversion starts
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`include "sar_ctrl_map.svh"
module sar_conversion_control #(
    parameter int STEP_CYCLES = 1,
    parameter int FIFO_DEPTH  = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conversion_start_n,
    input  wire logic        input_range_select,
    input  wire logic        output_format_select,
    input  wire logic        power_down_request,
    input  wire logic        reset_request,
    input  wire logic        chip_select_n,
    input  wire logic        comparator_out,
    output logic             sample_track,
    output logic      [15:0] sampling_capacitor_array,
    output logic             busy,
    output logic      [1:0]  span_select,
    output logic             nap_active,
    output logic             sleep_active,
    output logic      [15:0] data_out,
    output logic             data_oe
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // At least one clock per step; the step timer is 8 bits wide and
    // the four-bit status level field holds a depth of 8 at most
    if (STEP_CYCLES < 1 || STEP_CYCLES > 255 || FIFO_DEPTH > 8) begin : g_bad_param
        $error("sar_conversion_control: STEP_CYCLES or FIFO_DEPTH out of range");
    end

    sar_ctrl_pkg::conv_state_t state_r;
    logic [15:0]   sar_r;
    logic [3:0]    bit_idx_r;
    logic [7:0]    step_cnt_r;
    logic          start_prev_r;
    logic [1:0]    ctrl_r;
    logic [15:0]   data_out_r;
    logic          data_valid_r;
    logic [15:0]   push_data_r;
    logic [15:0]   trial;
    logic [15:0]   decided;
    logic [15:0]   coded;
    logic          start_fall;
    logic          accept;
    logic          step_done;
    logic          last_step;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          fifo_pop;
    logic [15:0]   fifo_out_data;
    logic [LW-1:0] fifo_level;
    logic          apb_access;
    logic          addr_hit;

    // Start edge detect; inputs arrive synchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_prev_r <= 1'b1;
        end else begin
            start_prev_r <= conversion_start_n;
        end
    end

    assign start_fall = start_prev_r && !conversion_start_n;
    // Starts while busy, powered down, asleep or in reset are dropped, not queued
    assign accept = start_fall && (state_r == sar_ctrl_pkg::ST_ACQ)
                    && !power_down_request && !ctrl_r[`SAR_CTRL_SLEEP]
                    && !reset_request;

    // Internal step timer stands in for the conversion oscillator
    assign step_done = (step_cnt_r == 8'(STEP_CYCLES - 1));
    assign last_step = step_done && (bit_idx_r == '0);

    // Trial code: decided bits plus the bit under test
    assign trial   = sar_r | (16'h0001 << bit_idx_r);
    assign decided = comparator_out ? trial : sar_r;

    // Raw search gives straight binary; signed codings flip the MSB
    always_comb begin
        coded = decided;
        unique case ({input_range_select, output_format_select})
            `SAR_SEL_FD_2C: coded = decided ^ `SAR_MSB_TRIAL;
            `SAR_SEL_FD_OB: coded = decided;
            `SAR_SEL_PB_2C: coded = decided ^ `SAR_MSB_TRIAL;
            `SAR_SEL_PU_SB: coded = decided;
        endcase
    end

    // Span request to the analog front end
    always_comb begin
        unique case ({input_range_select, output_format_select})
            `SAR_SEL_PB_2C: span_select = sar_ctrl_pkg::SPAN_BIPOLAR;
            `SAR_SEL_PU_SB: span_select = sar_ctrl_pkg::SPAN_UNIPOLAR;
            default:        span_select = sar_ctrl_pkg::SPAN_FULL_DIFF;
        endcase
    end

    // Sequencer: acquire, search, hand the code to the FIFO
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= sar_ctrl_pkg::ST_ACQ;
        end else if (reset_request) begin
            state_r <= sar_ctrl_pkg::ST_ACQ;
        end else begin
            unique case (state_r)
                sar_ctrl_pkg::ST_ACQ:  if (accept) state_r <= sar_ctrl_pkg::ST_CONV;
                sar_ctrl_pkg::ST_CONV: if (last_step) state_r <= sar_ctrl_pkg::ST_HOLD;
                // Full FIFO stalls here with busy high until software drains it
                sar_ctrl_pkg::ST_HOLD: if (fifo_in_ready) state_r <= sar_ctrl_pkg::ST_ACQ;
            endcase
        end
    end

    // Search register, bit pointer and step timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_r      <= `SAR_CODE_RST;
            bit_idx_r  <= `SAR_MSB_IDX;
            step_cnt_r <= `SAR_STEP_RST;
        end else if (accept) begin
            sar_r      <= `SAR_CODE_RST;
            bit_idx_r  <= `SAR_MSB_IDX;
            step_cnt_r <= `SAR_STEP_RST;
        end else if (state_r == sar_ctrl_pkg::ST_CONV) begin
            if (step_done) begin
                sar_r      <= decided;
                bit_idx_r  <= bit_idx_r - 1'b1;
                step_cnt_r <= `SAR_STEP_RST;
            end else begin
                step_cnt_r <= step_cnt_r + 1'b1;
            end
        end
    end

    // Output register loads only when a search completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out_r  <= `SAR_CODE_RST;
            push_data_r <= `SAR_CODE_RST;
        end else if (state_r == sar_ctrl_pkg::ST_CONV && last_step && !reset_request) begin
            data_out_r  <= coded;
            push_data_r <= coded;
        end
    end

    // Bus released after reset until a fresh result exists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_valid_r <= 1'b0;
        end else if (reset_request) begin
            data_valid_r <= 1'b0;
        end else if (state_r == sar_ctrl_pkg::ST_CONV && last_step) begin
            data_valid_r <= 1'b1;
        end
    end

    assign data_out     = data_out_r;
    assign data_oe      = data_valid_r && !chip_select_n;
    assign busy         = (state_r != sar_ctrl_pkg::ST_ACQ);
    assign sample_track = (state_r == sar_ctrl_pkg::ST_ACQ);
    assign sampling_capacitor_array = (state_r == sar_ctrl_pkg::ST_CONV) ? trial : sar_r;
    // Nap drops out while converting; sleep holds until software clears it
    assign nap_active   = ctrl_r[`SAR_CTRL_NAP] && !busy;
    assign sleep_active = ctrl_r[`SAR_CTRL_SLEEP] || power_down_request;

    // Results queue for software; fastest rate is the clock over the search length plus two cycles
    result_fifo #(
        .WIDTH (`SAR_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (state_r == sar_ctrl_pkg::ST_HOLD),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_r),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // APB slave: zero wait states, error on unmapped offsets
    assign apb_access = psel && penable;
    assign addr_hit   = (paddr == `SAR_OFF_CTRL) || (paddr == `SAR_OFF_STATUS)
                        || (paddr == `SAR_OFF_RESULT) || (paddr == `SAR_OFF_LAST);
    assign pready     = 1'b1;
    assign pslverr    = apb_access && !addr_hit;
    assign fifo_pop   = apb_access && !pwrite && (paddr == `SAR_OFF_RESULT);

    // Control register: nap and sleep requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `SAR_CTRL_RST;
        end else if (apb_access && pwrite && paddr == `SAR_OFF_CTRL) begin
            ctrl_r <= pwdata[1:0];
        end
    end

    // Read mux; reading the result word pops the FIFO
    always_comb begin
        prdata = 32'h0;
        unique case (paddr)
            `SAR_OFF_CTRL:   prdata[1:0] = ctrl_r;
            `SAR_OFF_STATUS: begin
                prdata[`SAR_ST_BUSY]   = busy;
                prdata[`SAR_ST_PD]     = power_down_request;
                prdata[`SAR_ST_RANGE]  = input_range_select;
                prdata[`SAR_ST_FORMAT] = output_format_select;
                prdata[`SAR_ST_VALID]  = data_valid_r;
                prdata[`SAR_ST_LVL_HI:`SAR_ST_LVL_LO] = 4'(fifo_level);
            end
            `SAR_OFF_RESULT: begin
                prdata[`SAR_RES_VALID] = fifo_out_valid;
                prdata[15:0]           = fifo_out_valid ? fifo_out_data : `SAR_CODE_RST;
            end
            `SAR_OFF_LAST:   prdata[15:0] = data_out_r;
            default:         prdata = 32'h0;
        endcase
    end

    // Helper: cycles spent converting; wide enough for 16 steps of 255 cycles
    logic [11:0] conv_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cnt_r <= 12'h000;
        end else if (accept) begin
            conv_cnt_r <= 12'h000;
        end else if (state_r == sar_ctrl_pkg::ST_CONV) begin
            conv_cnt_r <= conv_cnt_r + 1'b1;
        end
    end

    sequence s_start;
        accept && !reset_request;
    endsequence

    sequence s_first_trial;
        busy && !sample_track && sampling_capacitor_array == `SAR_MSB_TRIAL;
    endsequence

    property p_busy_rise;
        @(posedge pclk) disable iff (!presetn) s_start |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");

    property p_first_trial;
        @(posedge pclk) disable iff (!presetn) s_start |=> s_first_trial;
    endproperty
    a_first_trial: assert property (p_first_trial) else $error("no MSB trial");

    property p_track_ends;
        @(posedge pclk) disable iff (!presetn) start_fall && sample_track
            && !power_down_request && !ctrl_r[`SAR_CTRL_SLEEP] && !reset_request
            |=> !sample_track;
    endproperty
    a_track_ends: assert property (p_track_ends) else $error("sample not held");

    property p_conv_len;
        @(posedge pclk) disable iff (!presetn)
            (state_r == sar_ctrl_pkg::ST_CONV) && last_step && !reset_request
            |-> conv_cnt_r == 12'(`SAR_BITS * STEP_CYCLES - 1);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("wrong search length");

    property p_pd_ignore;
        @(posedge pclk) disable iff (!presetn)
            power_down_request && sample_track |=> sample_track;
    endproperty
    a_pd_ignore: assert property (p_pd_ignore) else $error("start taken in power-down");

    property p_reset_abort;
        @(posedge pclk) disable iff (!presetn)
            reset_request |=> sample_track && !data_oe;
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");

    property p_hold_result;
        @(posedge pclk) disable iff (!presetn)
            (state_r != sar_ctrl_pkg::ST_CONV) |=> $stable(data_out_r);
    endproperty
    a_hold_result: assert property (p_hold_result) else $error("result changed");

    property p_no_latency;
        @(posedge pclk) disable iff (!presetn)
            $fell(busy) && !$past(reset_request) |-> data_out == push_data_r;
    endproperty
    a_no_latency: assert property (p_no_latency) else $error("stale result");

    property p_ob_coding;
        @(posedge pclk) disable iff (!presetn)
            {input_range_select, output_format_select} == `SAR_SEL_FD_OB
            |-> coded == decided && (decided ^ `SAR_MSB_TRIAL) != coded;
    endproperty
    a_ob_coding: assert property (p_ob_coding) else $error("offset coding wrong");

endmodule // sar_conversion_control

// ---- test/conv_host_model.sv ----
// Host and comparator model on the far side of the conversion control
`timescale 1ns/1ps
module conv_host_model (
    input  wire logic        pclk,
    input  wire logic        busy,
    input  wire logic        data_oe,
    input  wire logic [15:0] data_out,
    input  wire logic [15:0] sampling_capacitor_array,
    input  wire logic [15:0] target,
    output logic             conversion_start_n,
    output logic             comparator_out,
    output logic      [15:0] got_code
);
    logic busy_q = 1'b0;

    initial begin
        conversion_start_n = 1'b1;
        got_code           = 16'h0000;
    end

    // Ideal comparator: keep the trial bit while the held input reaches it
    assign comparator_out = (target >= sampling_capacitor_array);

    // Start request: a falling edge, held low two edges, then back high
    task automatic pulse_start();
        @(posedge pclk);
        conversion_start_n <= 1'b0;
        repeat (2) @(posedge pclk);
        conversion_start_n <= 1'b1;
    endtask

    // Result taken at the busy fall, only while the bus is driven
    always @(posedge pclk) begin
        busy_q <= busy;
        if (busy_q === 1'b1 && busy === 1'b0 && data_oe === 1'b1) begin
            got_code <= data_out;
        end
    end
endmodule // conv_host_model

// ---- test/tb.sv ----
// Self-checking bench: APB registers, start link, coding, abort and result FIFO
`timescale 1ns/1ps
module tb;
    logic        pclk                 = 1'b0;
    logic        presetn              = 1'b0;
    logic        psel                 = 1'b0;
    logic        penable              = 1'b0;
    logic        pwrite               = 1'b0;
    logic [7:0]  paddr                = 8'h00;
    logic [31:0] pwdata               = 32'h0;
    logic        input_range_select   = 1'b0;
    logic        output_format_select = 1'b0;
    logic        power_down_request   = 1'b0;
    logic        reset_request        = 1'b0;
    logic        chip_select_n        = 1'b0;
    logic [15:0] tgt                  = 16'h0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        conversion_start_n;
    logic        comparator_out;
    logic        sample_track;
    logic [15:0] sampling_capacitor_array;
    logic        busy;
    logic [1:0]  span_select;
    logic        nap_active;
    logic        sleep_active;
    logic [15:0] data_out;
    logic        data_oe;
    logic [31:0] rd;
    logic        err;
    logic [15:0] t;
    logic [15:0] c0;
    logic [15:0] q[$];
    int          failures = 0;
    int          n_checks = 0;
    int          run_len  = 0;
    int          last_run = 0;
    int          k;
    logic [15:0] got_code_w;

    sar_conversion_control #(.STEP_CYCLES(1), .FIFO_DEPTH(8)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conversion_start_n(conversion_start_n),
        .input_range_select(input_range_select),
        .output_format_select(output_format_select),
        .power_down_request(power_down_request), .reset_request(reset_request),
        .chip_select_n(chip_select_n), .comparator_out(comparator_out),
        .sample_track(sample_track), .sampling_capacitor_array(sampling_capacitor_array),
        .busy(busy), .span_select(span_select), .nap_active(nap_active),
        .sleep_active(sleep_active), .data_out(data_out), .data_oe(data_oe)
    );

    conv_host_model u_host (
        .pclk(pclk), .busy(busy), .data_oe(data_oe), .data_out(data_out),
        .sampling_capacitor_array(sampling_capacitor_array), .target(tgt),
        .conversion_start_n(conversion_start_n), .comparator_out(comparator_out),
        .got_code(got_code_w)
    );

    // 10 MHz clock
    always #50 pclk = ~pclk;

    // Length of each busy stretch in clock edges
    always @(posedge pclk) begin
        if (busy === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            last_run <= run_len;
            run_len  <= 0;
        end
    end

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            failures++;
            stop_test();
        end
    endtask

    // Bounded wait for busy low; a hang ends the run
    task automatic wait_idle(input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge pclk);
            if (busy === 1'b0) break;
        end
        if (i == lim) begin
            failures++;
            stop_test();
        end
        #1;
    endtask

    // Expected code from the raw search value and the format strap
    function automatic logic [15:0] exp_code(input logic [15:0] v, input logic f);
        return f ? v : (v ^ 16'h8000);
    endfunction

    task automatic conv(input logic [15:0] v);
        tgt <= v;
        u_host.pulse_start();
        wait_idle(200);
    endtask

    // Convert, check timing and code, then pop the FIFO head
    task automatic conv_pop(input logic [15:0] v, input logic f);
        logic [15:0] e;
        e = exp_code(v, f);
        conv(v);
        check(last_run, 17);
        check(sample_track, 1);
        check(data_out, e);
        check(got_code_w, e);
        apb(1'b0, 8'h08, 32'h0);
        check(rd, {15'h0, 1'b1, e});
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        #1;
        check({busy, data_oe, sample_track, data_out}, 19'h10000);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        check(err, 1'b1);
        apb(1'b1, 8'h04, 32'hffffffff);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0);
        // Every strap pair; pairs 00 and 01 share a target
        for (k = 0; k < 4; k++) begin
            input_range_select   <= k[1];
            output_format_select <= k[0];
            t = 16'h1234 + 16'(k / 2) * 16'h6a5b;
            conv_pop(t, k[0]);
            check(span_select, k == 3 ? 2'b10 : (k == 2 ? 2'b01 : 2'b00));
            if (k == 0) c0 = data_out;
            if (k == 1) check(data_out, c0 ^ 16'h8000);
        end
        apb(1'b0, 8'h0c, 32'h0);
        check(rd, {16'h0, t});
        chip_select_n <= 1'b1;
        #1;
        check(data_oe, 0);
        chip_select_n <= 1'b0;
        // A second start edge mid conversion is dropped
        tgt <= 16'h5a5a;
        u_host.pulse_start();
        u_host.pulse_start();
        wait_idle(200);
        check(last_run, 17);
        repeat (4) @(posedge pclk);
        #1;
        check({busy, data_out}, 17'h05a5a);
        apb(1'b0, 8'h08, 32'h0);
        // Power-down pin and sleep block starts; nap still converts
        power_down_request <= 1'b1;
        u_host.pulse_start();
        repeat (3) @(posedge pclk);
        #1;
        check({busy, sleep_active}, 2'b01);
        power_down_request <= 1'b0;
        apb(1'b1, 8'h00, 32'h2);
        u_host.pulse_start();
        repeat (3) @(posedge pclk);
        #1;
        check({busy, sleep_active, data_out}, 18'h15a5a);
        apb(1'b1, 8'h00, 32'h1);
        #1;
        check({nap_active, sleep_active}, 2'b10);
        conv_pop(16'h0f0f, 1'b1);
        apb(1'b1, 8'h00, 32'h0);
        // Reset request aborts a conversion and releases the bus
        tgt <= 16'h7777;
        u_host.pulse_start();
        repeat (3) @(posedge pclk);
        #1;
        check({busy, sample_track}, 2'b10);
        reset_request <= 1'b1;
        @(posedge pclk);
        reset_request <= 1'b0;
        #1;
        check({busy, sample_track, data_oe}, 3'b010);
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        // Fill the FIFO, including both end codes
        for (k = 0; k < 8; k++) begin
            t = (k == 7) ? 16'hffff : 16'(k * 16'h2001);
            q.push_back(t);
            conv(t);
            check({16'(last_run), data_out}, {16'd17, t});
        end
        apb(1'b0, 8'h04, 32'h0);
        check({rd[11:8], rd[4]}, 5'h11);
        tgt <= 16'habcd;
        u_host.pulse_start();
        repeat (30) @(posedge pclk);
        #1;
        check({busy, data_out}, 17'h1abcd);
        q.push_back(16'habcd);
        for (k = 0; k < 9; k++) begin
            apb(1'b0, 8'h08, 32'h0);
            check(rd, {15'h0, 1'b1, q.pop_front()});
            if (k == 0) wait_idle(50);
        end
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        stop_test();
    end
endmodule // tb
